// [hdl/dwrm_buf2.sv]
// Two-entry buffer between write beats and the array port.
// Assumes one clock; the drain side may stall at will.
`timescale 1ns/1ps
module dwrm_buf2 #(
	parameter int W = 21
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] mem_r [2];
	logic         wp_r;
	logic         rp_r;
	logic [1:0]   cnt_r;
	logic         push;
	logic         pop;

	// Handshakes on both sides
	assign push      = in_valid && cnt_r != 2'h2;
	assign pop       = out_ready && cnt_r != 2'h0;
	assign in_ready  = cnt_r != 2'h2;
	assign out_valid = cnt_r != 2'h0;
	assign out_data  = mem_r[rp_r];

	// Storage and pointers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push)
				wp_r <= !wp_r;
			if (pop)
				rp_r <= !rp_r;
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// A stalled drain keeps the head word still
	property p_hold;
		out_valid && !out_ready |=> out_valid && $stable(out_data);
	endproperty
	a_hold: assert property (p_hold) else $error("buffer head changed while stalled");
endmodule // dwrm_buf2

// [hdl/dwrm_burst_seq.sv]
// Column sequencer for one write burst: wrap within the aligned block.
// Assumes the caller loads at burst start and advances once per beat.
`timescale 1ns/1ps
module dwrm_burst_seq (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       load,
	input  wire logic [2:0] start,
	input  wire logic       len8,
	input  wire logic       interleave,
	input  wire logic       advance,
	output logic [2:0]      col_low,
	output logic            last
);
	logic [2:0] start_r;
	logic [2:0] beat_r;

	// Low column bits for a beat, both orderings
	function automatic logic [2:0] dwrm_col_at(input logic [2:0] s, input logic [2:0] b,
		input logic l8, input logic il);
		logic [2:0] bb;
		bb = l8 ? b : {1'b0, b[1:0]};
		if (il)
			return s ^ bb;
		return {s[2] ^ bb[2], s[1:0] + bb[1:0]};
	endfunction

	assign col_low = dwrm_col_at(start_r, beat_r, len8, interleave);
	assign last    = beat_r == (len8 ? 3'h7 : 3'h3);

	// Beat counter and captured start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_r <= 3'h0;
			beat_r  <= 3'h0;
		end else if (load) begin
			start_r <= start;
			beat_r  <= 3'h0;
		end else if (advance) begin
			beat_r <= last ? 3'h0 : beat_r + 3'h1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Interleaved order is start xor beat count
	property p_interleave;
		interleave && len8 && !load |-> col_low == (start_r ^ beat_r);
	endproperty
	a_interleave: assert property (p_interleave) else $error("interleaved column wrong");

	// Sequential length eight stays in the start nibble for four beats
	property p_nibble;
		!interleave && len8 && !load && !beat_r[2] |-> col_low[2] == start_r[2];
	endproperty
	a_nibble: assert property (p_nibble) else $error("sequential nibble left early");
endmodule // dwrm_burst_seq

// [hdl/dwrm_top.sv]
// Write, precharge, refresh, self refresh and mode register logic of the memory.
// Assumes commands on clk from a controller; array write port may stall.
`timescale 1ns/1ps
`include "dwrm_defs.svh"
module dwrm_top #(
	parameter int ROW_CLOSE_CYC = `DWRM_ROW_CLOSE_CYC,
	parameter int MAX_AL        = `DWRM_MAX_AL
) (
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	input  wire logic                       cke,
	input  wire dwrm_pkg::dwrm_pins_s       pins,
	input  wire logic [2:0]                 posted_extra_latency,
	input  wire logic                       beat_valid,
	input  wire logic [7:0]                 beat_data,
	input  wire logic                       byte_mask_input,
	output logic                            beat_ready,
	output logic                            arr_valid,
	input  wire logic                       arr_ready,
	output dwrm_pkg::dwrm_beat_s            arr_beat,
	output logic [`DWRM_MODE_W-1:0]         operating_mode_word,
	output logic [2:0]                      read_latency,
	output logic                            burst_beats8,
	output logic                            test_mode,
	output logic                            slow_exit_pd,
	output logic [7:0]                      bank_open,
	output logic [7:0]                      bank_closing,
	output logic                            refresh_pulse,
	output logic [12:0]                     refresh_row,
	output logic                            self_refresh,
	output logic                            dll_on,
	output logic                            dll_restart_pulse,
	output logic                            dll_settled
);
	import dwrm_pkg::*;

	dwrm_cmd_e    cmd;
	logic         cke_prev_r;
	logic [16:0]  mode_r;
	logic         test_r;
	logic         dll_pulse_r;
	logic [7:0]   lock_cnt_r;
	logic         sr_r;
	logic         dll_on_r;
	logic         ref_pulse_r;
	logic [12:0]  ref_row_r;
	dwrm_wcmd_s   dly_r [MAX_AL+1];
	dwrm_wcmd_s   tap;
	dwrm_wstate_e wst_r;
	dwrm_wcmd_s   cur_r;
	logic [3:0]   wr_cnt_r;
	logic [7:0]   open_r;
	logic [7:0]   closing_r;
	logic [3:0]   pre_cnt_r [8];
	logic [7:0]   pre_vec;
	logic         beat_take;
	logic         last_beat;
	logic [2:0]   col_low;
	logic         buf_push;
	logic         buf_ready;
	logic         start_w;
	logic         len8;
	logic         upd;

	// Command decode; a command is live only with clock enable held high
	assign cmd     = (cke_prev_r && cke) ? dwrm_decode(pins) : DWRM_NOP;
	assign len8    = mode_r[`DWRM_F_BL_HI:`DWRM_F_BL_LO] == `DWRM_BL8_CODE;
	assign tap     = dly_r[(posted_extra_latency > MAX_AL) ? MAX_AL : posted_extra_latency];
	assign start_w = tap.valid;
	assign upd     = cmd == DWRM_LOAD && pins.ba[1:0] == 2'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cke_prev_r <= 1'b0;
		else
			cke_prev_r <= cke;
	end

	// Mode register load; test bit guards all other fields
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r      <= `DWRM_MODE_RST;
			test_r      <= 1'b0;
			dll_pulse_r <= 1'b0;
		end else begin
			dll_pulse_r <= 1'b0;
			if (upd) begin
				test_r <= pins.addr[`DWRM_F_TEST];
				if (!pins.addr[`DWRM_F_TEST]) begin
					mode_r      <= {pins.ba, pins.addr};
					dll_pulse_r <= pins.addr[`DWRM_F_DLL];
				end
			end else if (mode_r[`DWRM_F_DLL]) begin
				mode_r[`DWRM_F_DLL] <= 1'b0;
			end
			if (sr_r && cke)
				dll_pulse_r <= 1'b1;
		end
	end

	// Lock wait counter after any DLL restart
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			lock_cnt_r <= 8'h00;
		else if (dll_pulse_r)
			lock_cnt_r <= 8'(`DWRM_DLL_LOCK_CYC);
		else if (lock_cnt_r != 8'h00 && dll_on_r)
			lock_cnt_r <= lock_cnt_r - 8'h01;
	end

	// Refresh with internal row address; self refresh on clock-enable low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_r        <= 1'b0;
			dll_on_r    <= 1'b1;
			ref_pulse_r <= 1'b0;
			ref_row_r   <= 13'h0000;
		end else begin
			ref_pulse_r <= cmd == DWRM_REFRESH;
			if (cmd == DWRM_REFRESH)
				ref_row_r <= ref_row_r + 13'h0001;
			if (!sr_r && cke_prev_r && !cke && dwrm_decode(pins) == DWRM_REFRESH) begin
				sr_r     <= 1'b1;
				dll_on_r <= 1'b0;
			end else if (sr_r && cke) begin
				sr_r     <= 1'b0;
				dll_on_r <= 1'b1;
			end
		end
	end

	// Posted write delay line, tapped at the extra latency
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i <= MAX_AL; i++)
				dly_r[i] <= '0;
		end else begin
			dly_r[0] <= '{valid: cmd == DWRM_WRITE, bank: pins.ba, col: pins.addr[9:0],
				auto_close: pins.addr[`DWRM_AUTO_CLOSE]};
			for (int i = 1; i <= MAX_AL; i++)
				dly_r[i] <= dly_r[i-1];
		end
	end

	// Write burst engine: beats, then recovery before auto close
	assign beat_take = wst_r == DWRM_BURST && beat_valid && buf_ready;
	assign buf_push  = beat_take && !byte_mask_input;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wst_r    <= DWRM_IDLE;
			cur_r    <= '0;
			wr_cnt_r <= 4'h0;
		end else begin
			case (wst_r)
				DWRM_IDLE: begin
					if (start_w) begin
						cur_r <= tap;
						wst_r <= DWRM_BURST;
					end
				end
				DWRM_BURST: begin
					if (beat_take && last_beat) begin
						wr_cnt_r <= {1'b0, mode_r[`DWRM_F_WR_HI:`DWRM_F_WR_LO]} + 4'h1;
						wst_r    <= cur_r.auto_close ? DWRM_RECOVER : DWRM_IDLE;
					end
				end
				DWRM_RECOVER: begin
					wr_cnt_r <= wr_cnt_r - 4'h1;
					if (wr_cnt_r == 4'h1)
						wst_r <= DWRM_IDLE;
				end
				default: wst_r <= DWRM_IDLE;
			endcase
		end
	end

	// Precharge requests: command, all-bank flag, or auto close
	always_comb begin
		pre_vec = 8'h00;
		if (cmd == DWRM_PRECHARGE)
			pre_vec = pins.addr[`DWRM_AUTO_CLOSE] ? 8'hFF : (8'h01 << pins.ba);
		if (wst_r == DWRM_RECOVER && wr_cnt_r == 4'h1)
			pre_vec[cur_r.bank] = 1'b1;
	end

	// Bank state: open rows and restartable row close timers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			open_r    <= 8'h00;
			closing_r <= 8'h00;
			for (int b = 0; b < 8; b++)
				pre_cnt_r[b] <= 4'h0;
		end else begin
			for (int b = 0; b < 8; b++) begin
				if (pre_vec[b]) begin
					open_r[b]    <= 1'b0;
					pre_cnt_r[b] <= 4'(ROW_CLOSE_CYC);
					closing_r[b] <= 1'b1;
				end else begin
					if (cmd == DWRM_ACTIVATE && pins.ba == 3'(b))
						open_r[b] <= 1'b1;
					if (pre_cnt_r[b] != 4'h0)
						pre_cnt_r[b] <= pre_cnt_r[b] - 4'h1;
					if (pre_cnt_r[b] == 4'h1)
						closing_r[b] <= 1'b0;
				end
			end
		end
	end

	dwrm_burst_seq u_seq (
		.clk        (clk),
		.rst_n      (rst_n),
		.load       (wst_r == DWRM_IDLE && start_w),
		.start      (tap.col[2:0]),
		.len8       (len8),
		.interleave (mode_r[`DWRM_F_ORDER]),
		.advance    (beat_take),
		.col_low    (col_low),
		.last       (last_beat)
	);

	dwrm_buf2 #(.W($bits(dwrm_beat_s))) u_buf (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (buf_push),
		.in_ready  (buf_ready),
		.in_data   ({cur_r.bank, len8 ? {cur_r.col[9:3], col_low} : {cur_r.col[9:2], col_low[1:0]},
			beat_data}),
		.out_valid (arr_valid),
		.out_ready (arr_ready),
		.out_data  (arr_beat)
	);

	// Status outputs
	assign beat_ready          = buf_ready && wst_r == DWRM_BURST;
	assign operating_mode_word = mode_r;
	assign read_latency        = mode_r[`DWRM_F_RL_HI:`DWRM_F_RL_LO];
	assign burst_beats8        = len8;
	assign test_mode           = test_r;
	assign slow_exit_pd        = mode_r[`DWRM_F_PD];
	assign bank_open           = open_r;
	assign bank_closing        = closing_r;
	assign refresh_pulse       = ref_pulse_r;
	assign refresh_row         = ref_row_r;
	assign self_refresh        = sr_r;
	assign dll_on              = dll_on_r;
	assign dll_restart_pulse   = dll_pulse_r;
	assign dll_settled         = lock_cnt_r == 8'h00 && dll_on_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_dll_load;
		upd && !pins.addr[`DWRM_F_TEST] && pins.addr[`DWRM_F_DLL];
	endsequence
	sequence s_dll_gone;
		dll_pulse_r ##1 !mode_r[`DWRM_F_DLL];
	endsequence

	property p_dll_clear;
		s_dll_load |=> s_dll_gone;
	endproperty
	a_dll_clear: assert property (p_dll_clear) else $error("DLL restart bit did not clear");

	property p_test_guard;
		upd && pins.addr[`DWRM_F_TEST] |=> $stable(mode_r) && test_r;
	endproperty
	a_test_guard: assert property (p_test_guard) else $error("test load changed fields");

	property p_load_all;
		upd && !pins.addr[`DWRM_F_TEST] && !pins.addr[`DWRM_F_DLL] |=> mode_r == $past({pins.ba, pins.addr});
	endproperty
	a_load_all: assert property (p_load_all) else $error("mode load lost a field");

	property p_pre_restart;
		cmd == DWRM_PRECHARGE && !pins.addr[`DWRM_AUTO_CLOSE]
			|=> pre_cnt_r[$past(pins.ba)] == 4'(ROW_CLOSE_CYC) && !open_r[$past(pins.ba)];
	endproperty
	a_pre_restart: assert property (p_pre_restart) else $error("precharge timer not restarted");

	property p_sr_dll;
		!sr_r && cke_prev_r && !cke && dwrm_decode(pins) == DWRM_REFRESH |=> sr_r && !dll_on_r;
	endproperty
	a_sr_dll: assert property (p_sr_dll) else $error("DLL not off in self refresh");

	property p_sr_exit;
		sr_r && cke |=> dll_on_r && dll_restart_pulse ##1 !dll_settled;
	endproperty
	a_sr_exit: assert property (p_sr_exit) else $error("DLL not restored on exit");

	property p_refresh;
		cmd == DWRM_REFRESH |=> refresh_pulse && refresh_row == $past(ref_row_r) + 13'h0001;
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh did not step row");

	property p_mask;
		beat_take && byte_mask_input && !(arr_valid && arr_ready) |=> $stable(u_buf.cnt_r);
	endproperty
	a_mask: assert property (p_mask) else $error("masked beat written");

	property p_posted;
		cmd == DWRM_WRITE && posted_extra_latency == 3'h2 && $stable(posted_extra_latency)
			|-> ##3 start_w;
	endproperty
	a_posted: assert property (p_posted) else $error("posted write started at wrong time");
endmodule // dwrm_top

// [pkg/dwrm_defs.svh]
// Constants of the write, refresh and mode logic: field positions, codes, timing.
// Assumes a 40 MHz command clock; included by bare name.
`ifndef DWRM_DEFS_SVH
`define DWRM_DEFS_SVH
`define DWRM_MODE_W        17
`define DWRM_MODE_RST      17'h00002
`define DWRM_F_BL_HI       2
`define DWRM_F_BL_LO       0
`define DWRM_F_ORDER       3
`define DWRM_F_RL_HI       6
`define DWRM_F_RL_LO       4
`define DWRM_F_TEST        7
`define DWRM_F_DLL         8
`define DWRM_F_WR_HI       11
`define DWRM_F_WR_LO       9
`define DWRM_F_PD          12
`define DWRM_BL4_CODE      3'h2
`define DWRM_BL8_CODE      3'h3
`define DWRM_AUTO_CLOSE    10
`define DWRM_CLK_NS        25
`define DWRM_ROW_CLOSE_NS  15
`define DWRM_ROW_CLOSE_CYC (((`DWRM_ROW_CLOSE_NS + `DWRM_CLK_NS - 1) / `DWRM_CLK_NS) < 1 ? 1 : \
	((`DWRM_ROW_CLOSE_NS + `DWRM_CLK_NS - 1) / `DWRM_CLK_NS))
`define DWRM_DLL_LOCK_CYC   200
`define DWRM_MAX_AL        5
`endif

// [pkg/dwrm_pkg.sv]
// Types of the write, refresh and mode logic.
// Assumes nothing beyond the constants header.
package dwrm_pkg;
	typedef enum logic [2:0] {
		DWRM_LOAD = 3'h0, DWRM_REFRESH = 3'h1, DWRM_PRECHARGE = 3'h2, DWRM_ACTIVATE = 3'h3,
		DWRM_WRITE = 3'h4, DWRM_READ = 3'h5, DWRM_TERM = 3'h6, DWRM_NOP = 3'h7
	} dwrm_cmd_e;

	typedef enum logic [1:0] {
		DWRM_IDLE = 2'h0, DWRM_BURST = 2'h1, DWRM_RECOVER = 2'h3
	} dwrm_wstate_e;

	typedef struct packed {
		logic        cs_n;
		logic        ras_n;
		logic        cas_n;
		logic        we_n;
		logic [2:0]  ba;
		logic [13:0] addr;
	} dwrm_pins_s;

	typedef struct packed {
		logic [2:0] bank;
		logic [9:0] col;
		logic [7:0] data;
	} dwrm_beat_s;

	typedef struct packed {
		logic       valid;
		logic [2:0] bank;
		logic [9:0] col;
		logic       auto_close;
	} dwrm_wcmd_s;

	// Command from the strobes; deselect reads as no operation
	function automatic dwrm_cmd_e dwrm_decode(input dwrm_pins_s p);
		if (p.cs_n)
			return DWRM_NOP;
		return dwrm_cmd_e'({p.ras_n, p.cas_n, p.we_n});
	endfunction
endpackage

// [tb/dwrm_ctrl_model.sv]
// Controller model: commands, clock enable, posted latency level and write beats.
// Assumes the device samples on the rising edge of clk; the bench calls its tasks.
`timescale 1ns/1ps
module dwrm_ctrl_model (
	input  wire logic            clk,
	input  wire logic            beat_ready,
	output dwrm_pkg::dwrm_pins_s pins,
	output logic                 cke,
	output logic [2:0]           posted_extra_latency,
	output logic                 beat_valid,
	output logic [7:0]           beat_data,
	output logic                 byte_mask_input
);
	import dwrm_pkg::*;

	// Deselected bus at time zero
	initial begin
		pins = '1;
		cke = 1'b1;
		posted_extra_latency = 3'h0;
		beat_valid = 1'b0;
		beat_data = 8'h00;
		byte_mask_input = 1'b0;
	end

	// One command for one edge, then deselect with inverted lines; two edges apart covers load spacing
	task automatic issue(input dwrm_cmd_e c, input logic [2:0] ba, input logic [13:0] a, input logic ck);
		dwrm_pins_s p;
		@(posedge clk);
		pins <= {1'b0, c, ba, a};
		cke <= ck;
		@(posedge clk);
		p = ~pins;
		p.cs_n = 1'b1;
		pins <= p;
	endtask

	// Mode load with reserved upper bits zero, only with all banks idle
	task automatic load(input logic [12:0] m);
		issue(DWRM_LOAD, 3'h0, {1'b0, m}, 1'b1);
	endtask

	// Refresh only with banks idle; clock enable low asks for self refresh
	task automatic refresh(input logic [13:0] a, input logic ck);
		issue(DWRM_REFRESH, 3'h0, a, ck);
	endtask

	// Leave self refresh by raising clock enable
	task automatic wake();
		@(posedge clk);
		cke <= 1'b1;
	endtask

	// Activate the bank before writing it, posted write with auto close
	task automatic write(input logic [2:0] b, input logic [9:0] col, input logic [2:0] al);
		posted_extra_latency <= al;
		issue(DWRM_ACTIVATE, b, 14'h0155, 1'b1);
		issue(DWRM_WRITE, b, {4'h1, col}, 1'b1);
	endtask

	// Beats held until taken; lat counts edges until the device first accepts
	task automatic send_beats(input int n, input logic [7:0] d0, input logic [7:0] mask, output int lat);
		int i;
		int j;
		logic r;
		i = 0;
		j = 0;
		lat = -1;
		beat_valid <= 1'b1;
		beat_data <= d0;
		byte_mask_input <= mask[0];
		while (i < n && j < 200) begin
			@(negedge clk);
			r = beat_ready;
			if (r && lat < 0)
				lat = j + 1;
			@(posedge clk);
			j++;
			if (r) begin
				i++;
				beat_data <= (i < n) ? d0 + 8'(i) : ~beat_data;
				byte_mask_input <= mask[i[2:0]];
			end
		end
		beat_valid <= 1'b0;
	endtask
endmodule // dwrm_ctrl_model

// [tb/tb_top.sv]
// Bench: resets the write, refresh and mode logic and runs command sequences against it.
// Assumes the controller model drives every command and beat input.
`timescale 1ns/1ps
module tb_top;
	import dwrm_pkg::*;

	localparam int CLOSE_CYC = 4;

	logic        clk, rst_n, cke, beat_valid, byte_mask_input, beat_ready, arr_valid, arr_ready;
	logic        burst_beats8, test_mode, slow_exit_pd, refresh_pulse, self_refresh;
	logic        dll_on, dll_restart_pulse, dll_settled, hold, take;
	dwrm_pins_s  pins;
	dwrm_beat_s  arr_beat, seen;
	dwrm_beat_s  got[$];
	logic [2:0]  posted_extra_latency, read_latency;
	logic [7:0]  beat_data, bank_open, bank_closing;
	logic [16:0] operating_mode_word;
	logic [12:0] refresh_row;
	int          n_errors, comparisons;

	dwrm_top #(.ROW_CLOSE_CYC(CLOSE_CYC)) dut (.clk, .rst_n, .cke, .pins, .posted_extra_latency, .beat_valid,
		.beat_data, .byte_mask_input, .beat_ready, .arr_valid, .arr_ready, .arr_beat, .operating_mode_word,
		.read_latency, .burst_beats8, .test_mode, .slow_exit_pd, .bank_open, .bank_closing, .refresh_pulse,
		.refresh_row, .self_refresh, .dll_on, .dll_restart_pulse, .dll_settled);

	dwrm_ctrl_model ctl (.clk, .beat_ready, .pins, .cke, .posted_extra_latency, .beat_valid, .beat_data,
		.byte_mask_input);

	// Clock of 25 ns
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Array port: handshake sampled settled, recorded at the edge; half-rate stall
	always @(negedge clk) begin
		take = arr_valid && arr_ready;
		seen = arr_beat;
	end
	always @(posedge clk) begin
		if (take)
			got.push_back(seen);
		arr_ready <= rst_n && !hold && !arr_ready;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got_v);
		comparisons++;
		if (got_v !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got_v);
		end
	endtask

	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask

	// Column order inside the aligned block
	function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] i, input logic l8, input logic il);
		logic [2:0] c;
		c = il ? s ^ i : {s[2] ^ i[2], s[1:0] + i[1:0]};
		if (!l8)
			c[2] = s[2];
		return c;
	endfunction

	// One auto-close write burst, beat 1 masked, checked at the array port
	task automatic wr(input logic [2:0] b, input int al, input logic l8, input logic il);
		dwrm_beat_s q[$];
		logic [9:0] col;
		logic [7:0] d0;
		int n, lat, j;
		n = l8 ? 8 : 4;
		col = {7'h55, b};
		d0 = {b, 5'h09};
		ctl.write(b, col, 3'(al));
		ctl.send_beats(n, d0, 8'h02, lat);
		chk("posted_wait", al + 2, lat);
		for (int i = 0; i < n; i++)
			if (i != 1)
				q.push_back({b, col[9:3], ord(col[2:0], 3'(i), l8, il), d0 + 8'(i)});
		j = 0;
		do begin
			tick();
			j++;
		end while (bank_open[b] === 1'b1 && j < 20);
		chk("close_delay_ok", 1, j >= 3 && j <= 6);
		chk("closing_after_write", 1, bank_closing[b]);
		j = 0;
		while (got.size() < q.size() && j < 60) begin
			tick();
			j++;
		end
		chk("beats_written", q.size(), got.size());
		while (q.size() > 0 && got.size() > 0)
			chk("array_beat", q.pop_front(), got.pop_front());
		got.delete();
	endtask

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog far beyond the expected thousand or so cycles
	initial begin
		#500000;
		n_errors++;
		conclude();
	end

	// Test sequence
	initial begin
		int j;
		logic [12:0] r;
		n_errors = 0;
		comparisons = 0;
		hold = 1'b0;
		rst_n = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("mode_reset", 17'h00002, operating_mode_word);
		chk("dll_reset_on", 1, dll_on);
		chk("banks_reset", 0, bank_open);
		done("reset");
		ctl.load(13'h1553);
		#1;
		chk("mode_loaded", 17'h01553, operating_mode_word);
		chk("dll_restart", 1, dll_restart_pulse);
		tick();
		chk("dll_bit_cleared", 17'h01453, operating_mode_word);
		chk("dll_pulse_end", 0, dll_restart_pulse);
		chk("read_latency", 5, read_latency);
		chk("len_eight", 1, burst_beats8);
		chk("slow_exit", 1, slow_exit_pd);
		chk("lock_early", 0, dll_settled);
		chk("no_array_write", 0, got.size());
		j = 2;
		while (dll_settled !== 1'b1 && j < 260) begin
			tick();
			j++;
		end
		chk("lock_wait_ok", 1, j >= 199 && j <= 203);
		done("mode");
		ctl.load(13'h0087);
		tick();
		chk("test_mode_on", 1, test_mode);
		chk("test_keeps_fields", 17'h01453, operating_mode_word);
		ctl.issue(DWRM_LOAD, 3'h1, 14'h0003, 1'b1);
		tick();
		chk("other_reg_ignored", 17'h01453, operating_mode_word);
		ctl.load(13'h0402);
		tick();
		chk("test_mode_off", 0, test_mode);
		chk("mode_reloaded", 17'h00402, operating_mode_word);
		chk("fast_exit", 0, slow_exit_pd);
		done("test_mode");
		r = refresh_row;
		ctl.refresh(14'h2A5A, 1'b1);
		#1;
		chk("refresh_pulse", 1, refresh_pulse);
		chk("refresh_row_step", r + 13'h1, refresh_row);
		ctl.refresh(14'h15A5, 1'b1);
		tick();
		chk("refresh_row_step2", r + 13'h2, refresh_row);
		tick();
		chk("refresh_pulse_end", 0, refresh_pulse);
		done("refresh");
		ctl.issue(DWRM_ACTIVATE, 3'h3, 14'h0011, 1'b1);
		ctl.issue(DWRM_ACTIVATE, 3'h5, 14'h0022, 1'b1);
		ctl.issue(DWRM_PRECHARGE, 3'h3, 14'h0000, 1'b1);
		ctl.issue(DWRM_PRECHARGE, 3'h3, 14'h0000, 1'b1);
		repeat (3) tick();
		chk("one_bank_closed", 8'h20, bank_open);
		chk("timer_restarted", 1, bank_closing[3]);
		ctl.issue(DWRM_PRECHARGE, 3'h0, 14'h0400, 1'b1);
		tick();
		chk("all_banks_closed", 0, bank_open);
		done("precharge");
		repeat (6) tick();
		ctl.refresh(14'h0000, 1'b0);
		tick();
		chk("self_refresh_on", 1, self_refresh);
		chk("dll_off", 0, dll_on);
		repeat (5) tick();
		ctl.wake();
		j = 0;
		do begin
			tick();
			j++;
		end while (self_refresh === 1'b1 && j < 4);
		chk("self_refresh_off", 0, self_refresh);
		chk("dll_back_on", 1, dll_on);
		chk("dll_reset_on_exit", 1, dll_restart_pulse);
		done("self_refresh");
		for (int m = 0; m < 4; m++) begin
			ctl.load(13'h0432 | {9'h0, m[0], 2'h0, m[1]});
			for (int s = 0; s < (m[1] ? 8 : 4); s++)
				wr(3'(s), s % 6, m[1], m[0]);
		end
		done("write_orders");
		hold = 1'b1;
		fork
			wr(3'h6, 0, 1'b1, 1'b1);
			begin
				repeat (16) tick();
				chk("input_held_off", 0, beat_ready);
				chk("buffer_head", 1, arr_valid);
				hold = 1'b0;
			end
		join
		done("buffer_full");
		conclude();
	end
endmodule // tb_top
